// ==== common/tx_front_map.svh ====
// offsets, field positions, reset values and code words of the
// transmit front end; assumes byte addresses on a 32-bit bus
`ifndef TX_FRONT_MAP_SVH
`define TX_FRONT_MAP_SVH
`define CTRL_OFS 8'h00
`define STAT_OFS 8'h04
`define CTRL_RST 9'h000
`define F_MLO 0
`define F_MHI 2
`define F_PAR 4
`define F_CKS 6
`define F_RATE 8
`define ALIGN_LOW_N 2'h2
`define WS_LEN 5'h10
`define K28_5_BYTE 8'hBC
`define K28_6B 6'h0F
`define C07_POS 10'h079
`define C07_NEG 10'h386
`define K285_NEG 10'h17C
`define K285_POS 10'h283
`endif

// ==== common/tx_front_pkg.sv ====
// types shared by the transmit front end
// assumes three-level selects are held as two-bit codes
package tx_front_pkg;
  typedef enum logic [1:0] {
    LVL_LOW = 2'b00, LVL_MID = 2'b01, LVL_HIGH = 2'b10
  } lvl_e;
  typedef enum logic [0:0] {WS_IDLE = 1'b0, WS_RUN = 1'b1} ws_e;
  typedef enum logic [1:0] {
    CMD_DATA = 2'b00, CMD_FILL = 2'b01, CMD_SPEC = 2'b10, CMD_SYNC = 2'b11
  } cmd_e;
  typedef struct packed {
    logic par;
    logic sc;
    logic [1:0] ct;
    logic [7:0] data;
  } char_s;
endpackage : tx_front_pkg

// ==== design/tx_front_end.sv ====
// transmit character front end: input register, phase-align buffer,
// parity check, 8b/10b encoder, word sync generator and shifter
// assumes clk_i is the reference clock and a classic Wishbone master
`timescale 1ns/1ps
`include "tx_front_map.svh"

module tx_front_end #(
  parameter int CHAR_DIV = 10,
  parameter int PA_DEPTH = 4
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic [7:0] tx_data_byte_i,
  input wire logic [1:0] tx_control_bits_i,
  input wire logic special_char_select_i,
  input wire logic tx_odd_parity_bit_i,
  input wire logic tx_input_clock_i,
  input wire logic tx_align_reset_n_i,
  output logic [9:0] tx_char_o,
  output logic tx_char_valid_o,
  output logic tx_serial_o,
  output logic tx_path_error_o
);
  import tx_front_pkg::*;

  localparam int PW = $clog2(PA_DEPTH);
  localparam logic [5:0] T6 [32] = '{
    6'h27, 6'h1D, 6'h2D, 6'h31, 6'h35, 6'h29, 6'h19, 6'h38,
    6'h39, 6'h25, 6'h15, 6'h34, 6'h0D, 6'h2C, 6'h1C, 6'h17,
    6'h1B, 6'h23, 6'h13, 6'h32, 6'h0B, 6'h2A, 6'h1A, 6'h3A,
    6'h33, 6'h26, 6'h16, 6'h36, 6'h0E, 6'h2E, 6'h1E, 6'h2B};
  localparam logic [3:0] T4 [8] = '{
    4'hB, 4'h9, 4'h5, 4'hC, 4'hD, 4'hA, 4'h6, 4'hE};

  // ----------------------------------------------------------------
  // 8b/10b encoder, returns {running disparity after, j..a}
  // ----------------------------------------------------------------
  function automatic logic [10:0] enc(input logic [7:0] b,
                                      input logic k, input logic rd);
    logic [5:0] s6;
    logic [3:0] s4;
    logic r6;
    logic r4;
    logic k28;
    logic a7;
    logic [9:0] c;
    k28 = k && (b[4:0] == 5'h1C);
    s6 = k28 ? `K28_6B : T6[b[4:0]];
    r6 = ($countones(s6) == 3) ? rd : ~rd;
    if (rd && (r6 != rd || b[4:0] == 5'h07)) s6 = ~s6;
    // alternate x.7 avoids a run of five in the e,i,f,g,h window
    a7 = (b[7:5] == 3'h7) && (k || (r6 ?
         (b[4:0] == 5'h0B || b[4:0] == 5'h0D || b[4:0] == 5'h0E) :
         (b[4:0] == 5'h11 || b[4:0] == 5'h12 || b[4:0] == 5'h14)));
    s4 = a7 ? 4'h7 : T4[b[7:5]];
    r4 = ($countones(s4) == 2) ? r6 : ~r6;
    if (($countones(s4) != 2 || b[7:5] == 3'h3) ? r6 : (k28 && !r6))
      s4 = ~s4;
    for (int i = 0; i < 6; i++) c[i] = s6[5-i];
    for (int i = 0; i < 4; i++) c[6+i] = s4[3-i];
    return {r4, c};
  endfunction : enc

  function automatic cmd_e classify(input lvl_e lo, input char_s ch);
    cmd_e c;
    c = CMD_DATA;
    case (lo)
      LVL_LOW: if (ch.ct[0]) c = ch.ct[1] ? CMD_SYNC : (ch.sc ? CMD_SPEC : CMD_FILL);
      LVL_MID: if (ch.ct[0]) c = ch.sc ? CMD_SYNC : (ch.ct[1] ? CMD_SPEC : CMD_FILL);
      default: c = cmd_e'(ch.ct);
    endcase
    return c;
  endfunction : classify

  // ----------------------------------------------------------------
  // register bus
  // ----------------------------------------------------------------
  logic [8:0] cfg_reg, cfg_next;
  logic ack_reg, ack_next;
  logic [31:0] rdat_reg, rdat_next;
  lvl_e mlo, mhi, pmode, cks;
  logic rate;
  logic pa_err_reg, pa_err_next;
  logic perr_reg, perr_next;
  logic rd_reg, rd_next;
  ws_e ws_reg, ws_next;
  logic [PW:0] cnt_reg, cnt_next;

  assign mlo = lvl_e'(cfg_reg[`F_MLO +: 2]);
  assign mhi = lvl_e'(cfg_reg[`F_MHI +: 2]);
  assign pmode = lvl_e'(cfg_reg[`F_PAR +: 2]);
  assign cks = lvl_e'(cfg_reg[`F_CKS +: 2]);
  assign rate = cfg_reg[`F_RATE];

  always_comb begin
    cfg_next = cfg_reg;
    ack_next = 1'b0;
    rdat_next = rdat_reg;
    if (wb_cyc_i && wb_stb_i && !ack_reg) begin
      ack_next = 1'b1;
      rdat_next = 32'h0000_0000;
      if (wb_adr_i == `CTRL_OFS) rdat_next = 32'(cfg_reg);
      if (wb_adr_i == `STAT_OFS)
        rdat_next = 32'({cnt_reg, ws_reg == WS_RUN, rd_reg, pa_err_reg, perr_reg});
    end
    // a write lands on the edge where the master sees ack
    if (wb_cyc_i && wb_stb_i && ack_reg && wb_we_i && wb_adr_i == `CTRL_OFS) begin
      if (wb_sel_i[0]) cfg_next[7:0] = wb_dat_i[7:0];
      if (wb_sel_i[1]) cfg_next[8] = wb_dat_i[8];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cfg_reg <= `CTRL_RST;
      ack_reg <= 1'b0;
      rdat_reg <= 32'h0000_0000;
    end else begin
      cfg_reg <= cfg_next;
      ack_reg <= ack_next;
      rdat_reg <= rdat_next;
    end
  end

  assign wb_ack_o = ack_reg;
  assign wb_dat_o = rdat_reg;

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  logic ck_s1, ck_s2, ck_s3, ar_s1, ar_s2;
  char_s din_s1, din_s2, raw;

  assign raw = '{par: tx_odd_parity_bit_i,
                 sc: special_char_select_i && (mlo != LVL_HIGH),
                 ct: tx_control_bits_i, data: tx_data_byte_i};

  // plain two-stage sync; the host data is only read here in input-clock mode
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      {ck_s1, ck_s2, ck_s3} <= 3'h0;
      {ar_s1, ar_s2} <= 2'h3;
      din_s1 <= '0;
      din_s2 <= '0;
    end else begin
      {ck_s1, ck_s2, ck_s3} <= {tx_input_clock_i, ck_s1, ck_s2};
      {ar_s1, ar_s2} <= {tx_align_reset_n_i, ar_s1};
      din_s1 <= raw;
      din_s2 <= din_s1;
    end
  end

  // ----------------------------------------------------------------
  // character clock, input register and phase-align buffer
  // ----------------------------------------------------------------
  logic [7:0] div_reg, div_next;
  logic [1:0] al_reg, al_next;
  char_s in_reg, in_next, cap, buf_out, cur;
  logic [PW-1:0] wp_reg, wp_next, rp_reg, rp_next;
  logic prime_reg, prime_next;
  char_s mem [PA_DEPTH];
  logic tick, ext, bufd, capt, wr, rd_en, buf_v, cur_v, recentre, al_rel;

  assign tick = (div_reg == 8'(CHAR_DIV - 1));
  assign ext = (cks != LVL_LOW);
  assign bufd = ext || rate;
  assign capt = ext ? (ck_s2 && !ck_s3) : tick;
  assign cap = ext ? din_s2 : raw;
  assign wr = bufd && capt;
  assign rd_en = tick && bufd && !prime_reg;
  assign buf_v = rd_en && (cnt_reg != '0);
  assign buf_out = mem[rp_reg];
  assign al_rel = ar_s2 && (al_reg == `ALIGN_LOW_N);
  assign cur = bufd ? buf_out : in_reg;
  assign cur_v = bufd ? buf_v : 1'b1;

  always_comb begin
    div_next = tick ? 8'h00 : div_reg + 8'h01;
    in_next = (!bufd && capt) ? cap : in_reg;
    al_next = ar_s2 ? 2'h0 : ((al_reg == `ALIGN_LOW_N) ? al_reg : al_reg + 2'h1);
    wp_next = wp_reg;
    rp_next = rp_reg;
    cnt_next = cnt_reg;
    prime_next = prime_reg;
    pa_err_next = pa_err_reg;
    // the buffer runs half full, so the input clock may slide
    // about PA_DEPTH/2 characters either way before it over or underflows
    if (wr && cnt_reg == (PW+1)'(PA_DEPTH)) pa_err_next = 1'b1;
    else if (wr) begin
      wp_next = wp_reg + 1'b1;
      cnt_next = cnt_next + 1'b1;
    end
    if (rd_en && cnt_reg == '0) pa_err_next = 1'b1;
    else if (rd_en) begin
      rp_next = rp_reg + 1'b1;
      cnt_next = cnt_next - 1'b1;
    end
    if (prime_reg && cnt_reg >= (PW+1)'(PA_DEPTH / 2)) prime_next = 1'b0;
    if (al_rel || recentre) begin
      wp_next = '0;
      rp_next = '0;
      cnt_next = '0;
      prime_next = 1'b1;
      pa_err_next = 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      div_reg <= 8'h00;
      in_reg <= '0;
      al_reg <= 2'h0;
      wp_reg <= '0;
      rp_reg <= '0;
      cnt_reg <= '0;
      prime_reg <= 1'b1;
      pa_err_reg <= 1'b0;
    end else begin
      div_reg <= div_next;
      in_reg <= in_next;
      al_reg <= al_next;
      wp_reg <= wp_next;
      rp_reg <= rp_next;
      cnt_reg <= cnt_next;
      prime_reg <= prime_next;
      pa_err_reg <= pa_err_next;
    end
  end

  // storage only, no reset needed; entries are written before use
  always_ff @(posedge clk_i) begin
    if (wr && cnt_reg != (PW+1)'(PA_DEPTH)) mem[wp_reg] <= cap;
  end

  // ----------------------------------------------------------------
  // parity, character selection, encoder, word sync, shifter
  // ----------------------------------------------------------------
  logic [3:0] wc_reg, wc_next;
  logic [9:0] char_reg, char_next, sh_reg, sh_next;
  logic vld_reg, vld_next;
  logic bypass, atomic, intr, full, perr_c, ratm, cont, start, c07, use_enc, kf, rev;
  logic [7:0] byte_s;
  logic [10:0] e_out, e_nrm;
  cmd_e cmd;

  assign bypass = (mhi == LVL_LOW);
  assign atomic = (mhi == LVL_MID);
  assign intr = !bypass && !atomic;
  assign full = (pmode == LVL_HIGH) || bypass;
  assign ratm = (ws_reg == WS_RUN) && atomic;
  assign perr_c = (pmode != LVL_LOW) && cur_v && !ratm &&
                  !(^{cur.data, cur.par, full ? cur.ct : 2'b00});
  assign cmd = classify(mlo, cur);
  assign cont = ratm ||
                (intr && ws_reg == WS_RUN && cur.ct == 2'b00 && cur_v && !perr_c);
  assign start = !bypass && cur_v && !perr_c && !cont && cmd == CMD_SYNC;
  assign e_out = enc(byte_s, kf, rev ? ~rd_reg : rd_reg);
  assign e_nrm = enc(byte_s, kf, rd_reg);

  always_comb begin
    ws_next = ws_reg;
    wc_next = wc_reg;
    rd_next = rd_reg;
    char_next = char_reg;
    perr_next = perr_reg;
    vld_next = 1'b0;
    sh_next = {1'b0, sh_reg[9:1]};
    recentre = 1'b0;
    byte_s = `K28_5_BYTE;
    kf = 1'b1;
    rev = 1'b0;
    use_enc = 1'b0;
    c07 = 1'b0;
    if (tick) begin
      vld_next = 1'b1;
      perr_next = perr_c;
      ws_next = WS_IDLE;
      wc_next = 4'h0;
      if (pa_err_reg && !(start && atomic)) c07 = 1'b1;
      else if (cont) begin
        // second and third K28.5 go out reversed, disparity follows the normal path
        use_enc = 1'b1;
        rev = (wc_reg == 4'h1) || (wc_reg == 4'h2);
        wc_next = wc_reg + 4'h1;
        if (5'(wc_reg) != `WS_LEN - 5'h01) ws_next = WS_RUN;
      end else if (perr_c) c07 = 1'b1;
      else if (!cur_v) use_enc = 1'b1;
      else if (!bypass) begin
        use_enc = 1'b1;
        case (cmd)
          CMD_DATA: begin
            byte_s = cur.data;
            kf = 1'b0;
          end
          CMD_SPEC: byte_s = cur.data;
          CMD_SYNC: begin
            ws_next = WS_RUN;
            wc_next = 4'h1;
            recentre = atomic && pa_err_reg;
          end
          default: byte_s = `K28_5_BYTE;
        endcase
      end
      if (c07) char_next = (bypass || rd_reg) ? `C07_POS : `C07_NEG;
      else if (use_enc) begin
        char_next = e_out[9:0];
        rd_next = e_nrm[10];
      end else char_next = {cur.ct, cur.data};
      sh_next = char_next;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ws_reg <= WS_IDLE;
      wc_reg <= 4'h0;
      rd_reg <= 1'b0;
      char_reg <= 10'h000;
      sh_reg <= 10'h000;
      perr_reg <= 1'b0;
      vld_reg <= 1'b0;
    end else begin
      ws_reg <= ws_next;
      wc_reg <= wc_next;
      rd_reg <= rd_next;
      char_reg <= char_next;
      sh_reg <= sh_next;
      perr_reg <= perr_next;
      vld_reg <= vld_next;
    end
  end

  assign tx_char_o = char_reg;
  assign tx_char_valid_o = vld_reg;
  assign tx_serial_o = sh_reg[0];
  assign tx_path_error_o = pa_err_reg || perr_reg;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence s_lsb2;
    tx_serial_o == tx_char_o[0] ##1 tx_serial_o == tx_char_o[1];
  endsequence
  property p_lsb_first;
    tick |=> s_lsb2;
  endproperty
  a_lsb_first: assert property (p_lsb_first) else $error("shifter order");
  property p_bypass_raw;
    tick && bypass && cur_v && !perr_c && !pa_err_reg |=> tx_char_o == $past(cur[9:0]);
  endproperty
  a_bypass_raw: assert property (p_bypass_raw) else $error("bypass data");
  property p_bypass_perr;
    tick && bypass && perr_c |=> tx_char_o == `C07_POS && tx_path_error_o;
  endproperty
  a_bypass_perr: assert property (p_bypass_perr) else $error("bypass parity");
  property p_parity_off;
    pmode == LVL_LOW |-> !perr_c;
  endproperty
  a_parity_off: assert property (p_parity_off) else $error("parity off");
  property p_pa_c07;
    tick && pa_err_reg && !recentre && !al_rel |=>
      (tx_char_o == `C07_POS || tx_char_o == `C07_NEG) && tx_path_error_o;
  endproperty
  a_pa_c07: assert property (p_pa_c07) else $error("align error char");
  property p_pa_hold;
    pa_err_reg && !al_rel && !recentre |=> pa_err_reg;
  endproperty
  a_pa_hold: assert property (p_pa_hold) else $error("align error dropped");
  property p_atomic_k;
    tick && ratm && !pa_err_reg |=> tx_char_o == `K285_NEG || tx_char_o == `K285_POS;
  endproperty
  a_atomic_k: assert property (p_atomic_k) else $error("word sync char");
  property p_k_flip;
    tick && use_enc && kf && byte_s == `K28_5_BYTE |=> rd_reg != $past(rd_reg);
  endproperty
  a_k_flip: assert property (p_k_flip) else $error("disparity");
  property p_align_init;
    al_rel |=> cnt_reg == '0 && prime_reg && !pa_err_reg;
  endproperty
  a_align_init: assert property (p_align_init) else $error("align reset");
endmodule : tx_front_end

// ==== test/host_char_model.sv ====
// host-side model: presents parallel characters and the input clock
// assumes the bench hands it each character; its clock stands still when stopped
`timescale 1ns/1ps
module host_char_model
  import tx_front_pkg::*;
(
  input wire logic clk_i,
  input wire logic run_i,
  input wire logic [15:0] half_ns_i,
  input wire tx_front_pkg::char_s char_i,
  output logic tx_input_clock_o,
  output tx_front_pkg::char_s char_o
);
  // ------------------------------------------------------------
  // input clock and character launch
  // ------------------------------------------------------------
  initial begin
    tx_input_clock_o = 1'b0;
    forever begin
      if (run_i) begin
        #(half_ns_i);
        tx_input_clock_o = 1'b1;
        #(half_ns_i);
        tx_input_clock_o = 1'b0;
      end else begin
        @(posedge run_i);
      end
    end
  end
  initial char_o = '0;
  // launch on the falling edge so the sampling edge sees settled bits
  always @(negedge tx_input_clock_o) char_o <= char_i;
  // with the input clock stopped the host runs from the reference clock
  always @(posedge clk_i) begin
    if (!run_i) begin
      char_o <= char_i;
    end
  end
endmodule : host_char_model

// ==== test/test_serial_tx_char_encode_front_end.sv ====
// bench for the transmit front end: registers, bypass and encoded characters,
// word sync and the phase-align buffer; assumes the host model drives characters
`timescale 1ns/1ps
`include "tx_front_map.svh"
module test_serial_tx_char_encode_front_end;
  import tx_front_pkg::*;
  // ------------------------------------------------------------
  // signals and instances
  // ------------------------------------------------------------
  logic clk_i, rst_i, cyc, stb, we, ack, run, align_n, valid, ser, perr, ick;
  logic [7:0] adr;
  logic [31:0] wdat, rdat;
  logic [15:0] half_ns;
  logic [9:0] chr;
  logic [9:0] pat [3];
  char_s hc, hq;
  int miscompares, checks_done, n;

  tx_front_end #(.CHAR_DIV(10), .PA_DEPTH(4)) DUT (.clk_i(clk_i), .rst_i(rst_i),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF),
    .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .tx_data_byte_i(hq.data),
    .tx_control_bits_i(hq.ct), .special_char_select_i(hq.sc),
    .tx_odd_parity_bit_i(hq.par), .tx_input_clock_i(ick), .tx_align_reset_n_i(align_n),
    .tx_char_o(chr), .tx_char_valid_o(valid), .tx_serial_o(ser), .tx_path_error_o(perr));
  host_char_model host (.clk_i(clk_i), .run_i(run), .half_ns_i(half_ns), .char_i(hc),
    .tx_input_clock_o(ick), .char_o(hq));

  initial begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end
  // ------------------------------------------------------------
  // tasks
  // ------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value at %0t ns: saw %h, expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic tally_and_finish;
    if (miscompares == 0 && checks_done > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : tally_and_finish

  task automatic give_up;
    miscompares++;
    tally_and_finish();
  endtask : give_up

  // one classic cycle; every signal moves only just after a rising edge
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                    output logic [31:0] q);
    int k;
    k = 0;
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do begin
      @(posedge clk_i);
      k++;
    end while (ack !== 1'b1 && k < 20);
    if (k >= 20) give_up();
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask : wb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    wb(1'b1, a, d, q);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic [31:0] m);
    logic [31:0] q;
    wb(1'b0, a, 32'h0, q);
    check(q & m, exp);
  endtask : rd

  task automatic wait_valid;
    int k;
    k = 0;
    do begin
      @(posedge clk_i);
      k++;
    end while (valid !== 1'b1 && k < 400);
    if (k >= 400) give_up();
  endtask : wait_valid

  task automatic wait_err(input logic lvl, input int lim);
    int k;
    k = 0;
    do begin
      @(posedge clk_i);
      k++;
    end while (perr !== lvl && k < lim);
    if (k >= lim) give_up();
  endtask : wait_err

  // sampled in the cycle after the load: character, then one bit per clock
  task automatic chk_char(input logic [9:0] exp);
    check(chr, exp);
    for (int i = 0; i < 10; i++) begin
      if (i > 0) @(posedge clk_i);
      check(ser, exp[i]);
    end
  endtask : chk_char

  // non-buffered path: the character shows one tick after its capture tick
  task automatic send(input char_s c, input logic [9:0] exp);
    wait_valid();
    hc <= c;
    wait_valid();
    // back to a parity-clean D0.0 so the character is taken only once
    hc <= mk(8'h00, 2'b00, 1'b0, 1'b0, 1'b0);
    wait_valid();
    chk_char(exp);
  endtask : send

  function automatic char_s mk(logic [7:0] d, logic [1:0] c, logic s, logic wct, logic bad);
    return {~^{d, c & {2{wct}}} ^ bad, s, c, d};
  endfunction : mk

  function automatic logic [31:0] ctl(lvl_e lo, lvl_e up, lvl_e par, lvl_e cks);
    return {24'h0, cks, par, up, lo};
  endfunction : ctl
  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    rst_i = 1'b1;
    cyc = 1'b0;
    stb = 1'b0;
    we = 1'b0;
    adr = 8'h00;
    wdat = 32'h0;
    run = 1'b0;
    align_n = 1'b1;
    half_ns = 16'd160;
    hc = '0;
    miscompares = 0;
    checks_done = 0;
    pat = '{10'h2A5, 10'h15A, 10'h301};
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    check({chr, valid, ser, perr}, 32'h0);
    rd(`CTRL_OFS, `CTRL_RST, 32'hFFFF_FFFF);
    rd(`STAT_OFS, 32'h0, 32'h6);
    wr(8'h40, 32'hFFFF_FFFF);
    rd(8'h40, 32'h0, 32'hFFFF_FFFF);
    rd(`CTRL_OFS, `CTRL_RST, 32'hFFFF_FFFF);
    // bypass: with parity off, bad parity and special select have no effect; with parity on, bad parity gives C07_POS
    for (int i = 0; i < 3; i++) begin
      send(mk(pat[i][7:0], pat[i][9:8], 1'b1, 1'b1, 1'b1), pat[i]);
      check(perr, 1'b0);
    end
    wr(`CTRL_OFS, ctl(LVL_LOW, LVL_LOW, LVL_MID, LVL_LOW));
    rd(`CTRL_OFS, ctl(LVL_LOW, LVL_LOW, LVL_MID, LVL_LOW), 32'h1FF);
    send(mk(8'h3C, 2'b01, 1'b0, 1'b1, 1'b0), 10'h13C);
    check(perr, 1'b0);
    send(mk(8'h3C, 2'b01, 1'b0, 1'b0, 1'b0), `C07_POS);
    check(perr, 1'b1);
    // encoded mode 5: fill, special and data codes with disparity tracking
    wr(`CTRL_OFS, ctl(LVL_HIGH, LVL_MID, LVL_MID, LVL_LOW));
    send(mk(8'h3C, 2'b01, 1'b0, 1'b0, 1'b0), `K285_NEG);
    check(perr, 1'b0);
    wr(`CTRL_OFS, ctl(LVL_HIGH, LVL_MID, LVL_HIGH, LVL_LOW));
    send(mk(8'h3C, 2'b01, 1'b0, 1'b0, 1'b0), `C07_POS);
    check(perr, 1'b1);
    send(mk(8'h3C, 2'b01, 1'b0, 1'b1, 1'b0), `K285_POS);
    send(mk(`K28_5_BYTE, 2'b10, 1'b0, 1'b1, 1'b0), `K285_NEG);
    send(mk(8'h00, 2'b00, 1'b0, 1'b1, 1'b0), 10'h346);
    // atomic word sync ignores the register, so bad parity inside goes unseen
    wait_valid();
    hc <= mk(8'h00, 2'b11, 1'b0, 1'b1, 1'b0);
    wait_valid();
    hc <= mk(8'h00, 2'b00, 1'b0, 1'b1, 1'b1);
    for (int i = 0; i < 16; i++) begin
      wait_valid();
      chk_char(((i == 1) || (i != 2 && i % 2 == 0)) ? `K285_POS : `K285_NEG);
    end
    wait_valid();
    chk_char(`C07_POS);
    // interruptible word sync is broken off by a parity error
    wr(`CTRL_OFS, ctl(LVL_HIGH, LVL_HIGH, LVL_HIGH, LVL_LOW));
    send(mk(8'h00, 2'b11, 1'b0, 1'b1, 1'b0), `K285_POS);
    hc <= mk(8'h00, 2'b00, 1'b0, 1'b1, 1'b1);
    wait_valid();
    wait_valid();
    wait_valid();
    check(chr === `C07_POS || chr === `C07_NEG, 1'b1);
    check(perr, 1'b1);
    // modes 3 and 4: special select picks the special code, or acts as a control bit
    wr(`CTRL_OFS, ctl(LVL_LOW, LVL_MID, LVL_LOW, LVL_LOW));
    send(mk(8'h1C, 2'b01, 1'b1, 1'b1, 1'b0), 10'h0BC);
    wr(`CTRL_OFS, ctl(LVL_MID, LVL_MID, LVL_LOW, LVL_LOW));
    send(mk(8'h1C, 2'b11, 1'b0, 1'b1, 1'b0), 10'h0BC);
    // buffered path: a fast input clock overruns the buffer
    hc <= mk(8'h00, 2'b00, 1'b0, 1'b1, 1'b0);
    wr(`CTRL_OFS, ctl(LVL_HIGH, LVL_MID, LVL_LOW, LVL_MID));
    align_n <= 1'b0;
    repeat (4) @(posedge clk_i);
    align_n <= 1'b1;
    run <= 1'b1;
    wait_err(1'b1, 3000);
    repeat (3) begin
      wait_valid();
      check(chr === `C07_POS || chr === `C07_NEG, 1'b1);
      check(perr, 1'b1);
    end
    // matched clock, then word sync recentres the buffer
    half_ns <= 16'd200;
    hc <= mk(8'h00, 2'b11, 1'b0, 1'b1, 1'b0);
    wait_err(1'b0, 1000);
    hc <= mk(8'h00, 2'b00, 1'b0, 1'b1, 1'b0);
    n = 0;
    repeat (1000) begin
      @(posedge clk_i);
      if (perr !== 1'b0) n++;
    end
    check(n, 0);
    run <= 1'b0;
    repeat (20) @(posedge clk_i);
    tally_and_finish();
  end
endmodule : test_serial_tx_char_encode_front_end
